// ==== psm_pkg.sv ====
package psm_pkg;
    // Register byte offsets
    localparam logic [3:0] PSM_CTL_OFS = 4'h0;
    localparam logic [3:0] PSM_STS_OFS = 4'h4;
    localparam logic [3:0] PSM_CORE_OFS = 4'h8;
    // power_control_reg fields
    localparam int PSM_CTL_LDO_VOLTAGE_SELECT_LSB = 14;
    localparam int PSM_CTL_STBCLR_BIT = 3;
    localparam int PSM_CTL_WAKECLR_BIT = 2;
    localparam int PSM_CTL_STBSEL_BIT = 1;
    localparam int PSM_CTL_REGULATOR_LOW_POWER_BIT = 0;
    localparam logic [1:0] PSM_LDO_VOLTAGE_SELECT_RST = 2'h1;
    localparam logic [1:0] PSM_LDO_VOLTAGE_SELECT_LOW = 2'h0;
    // power_status_reg fields
    localparam int PSM_STS_WPEN_BIT = 8;
    localparam int PSM_STS_STANDBY_ENTERED_FLAG_BIT = 1;
    localparam int PSM_STS_WUF_BIT = 0;
    // Core mode register fields
    localparam int PSM_CORE_DEEP_BIT = 0;
    localparam int PSM_CORE_SAI_BIT = 1;
    localparam int PSM_CORE_PAE_BIT = 2;
    // Timing
    localparam int PSM_CLK_MHZ = 25;
    localparam int PSM_POR_NS = 10000;
    localparam int PSM_OSC_WAKE_NS = 2000;
    localparam int PSM_LDO_WAKE_NS = 4000;
    localparam int PSM_POR_CYC = (PSM_POR_NS * PSM_CLK_MHZ + 999) / 1000;
    localparam int PSM_OSC_CYC = (PSM_OSC_WAKE_NS * PSM_CLK_MHZ + 999) / 1000;
    localparam int PSM_LDO_CYC = (PSM_LDO_WAKE_NS * PSM_CLK_MHZ + 999) / 1000;
    localparam logic [31:0] PSM_BOOT_ADDR = 32'h0000_0000;

    typedef enum logic [2:0] {
        PSM_POR = 3'b000,
        PSM_RUN = 3'b001,
        PSM_LSLEEP = 3'b010,
        PSM_DSLEEP = 3'b011,
        PSM_DWAKE = 3'b100,
        PSM_STANDBY = 3'b101
    } psm_state_t;
endpackage : psm_pkg

// ==== psm_ctrl.sv ====
// How it works
// - After core domain power-up, hold the whole domain in a power-on reset sequence.
// - Modes are configured first; entry happens at wait_for_interrupt, wait_for_event or, in light sleep with sleep_after_isr, lowest-priority handler return.
// - After any reset the device runs fully with every domain active.
// - ldo_voltage_select writable only with PLL off; low voltage driven while PLL off.
// - Light sleep stops only the core clock; other clocks keep running.
// - Light sleep wakes on interrupt, or event/interrupt-as-event when entered by wait_for_event.
// - sleep_after_isr 0 sleeps at wait; 1 light-sleeps on lowest-priority handler return, while deep sleep and standby still enter at wait.
// - Deep sleep stops all domain clocks and oscillators, PLLs; contents kept.
// - deep_sleep_request 1 and standby_select 0 before wait selects deep sleep.
// - Regulator low power in deep sleep per regulator_low_power, adding exit delay.
// - Deep sleep wakes only on event line interrupts or events.
// - Leaving deep sleep switches system clock to internal_8mhz_osc.
// - Pending event line flags at wait skip deep sleep entry.
// - Standby powers off the domain, regulator, oscillators and PLLs.
// - standby_entered_flag is set once standby has been entered.
// - Standby exits on reset pin low, RTC alarm, watchdog reset, wake_pin rise.
// - Standby exit performs full domain power-on reset; core fetches from address zero.
// - In standby all I/Os float except reset, RTC, crystal and enabled wake pins.
// - standby_entered_flag clears only on power reset or standby_flag_clear write.
// - wake_event_flag sets on wake pin or RTC alarm; clears on reset or write.
// - With wake_pin_enable set, a wake_pin rising edge wakes from standby.
`timescale 1ns/100ps
module psm_ctrl #(
    parameter int POR_CYC = psm_pkg::PSM_POR_CYC,
    parameter int OSC_CYC = psm_pkg::PSM_OSC_CYC,
    parameter int LDO_CYC = psm_pkg::PSM_LDO_CYC
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_b, // Power-on reset, active low
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic wfi_exec, // Core executed wait_for_interrupt
    input wire logic wfe_exec, // Core executed wait_for_event
    input wire logic isr_exit_lowest, // Return from lowest-priority handler
    input wire logic irq_any, // Any interrupt pending
    input wire logic event_any, // Any wakeup event
    input wire logic ext_line_irq, // Interrupt from event lines
    input wire logic ext_line_event, // Event from event lines
    input wire logic ext_pending_any, // Pending bits or peripheral flags set
    input wire logic pll_on, // PLL running
    input wire logic external_reset_pin_b, // Reset pin level
    input wire logic rtc_alarm, // RTC alarm
    input wire logic free_watchdog_rst, // Watchdog reset
    input wire logic wake_pin, // Wake pin level
    output logic core_rst_b, // Core domain reset, active low
    output logic [31:0] boot_addr, // Core fetch address after reset
    output logic core_clk_en, // Core clock gate
    output logic periph_clk_en, // All other domain clocks
    output logic osc_8m_en, // internal_8mhz_osc enable
    output logic osc_48m_en, // internal_48mhz_osc enable
    output logic high_speed_crystal_en, // high_speed_crystal enable
    output logic pll_en, // PLL enable
    output logic ldo_en, // Regulator on
    output logic ldo_low_power, // Regulator low-power
    output logic [1:0] ldo_voltage_out, // Regulator output select
    output logic domain_power_en, // Core domain supply
    output logic sysclk_to_8m, // Pulse: force system clock to 8 MHz osc
    output logic io_float, // Float general I/Os
    output logic wake_pin_keep // Keep wake pin active in standby
);
    import psm_pkg::*;

    psm_state_t state_q, state_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] ldo_voltage_select_q;
    logic stb_sel_q, regulator_low_power_q, wpen_q, standby_entered_flag_q, wuf_q;
    logic deep_q, sai_q, pae_q;
    logic via_wfe_q, wake_prev_q;
    logic [15:0] cnt_q;
    logic wr_ok, rd_go, wake_rise, wait_go, lwake, dwake, swake, dom_rst;
    logic wr_ctl, wr_sts, wr_core;

    function automatic logic psm_hit(input logic [3:0] a, input logic [3:0] ofs);
        psm_hit = (a[3:2] == ofs[3:2]);
    endfunction : psm_hit

    // One wait cycle per access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_ok = avs_write & ack_q;
    assign rd_go = avs_read & ~ack_q;
    assign wr_ctl = wr_ok & psm_hit(avs_address, PSM_CTL_OFS) & avs_byteenable[0];
    assign wr_sts = wr_ok & psm_hit(avs_address, PSM_STS_OFS) & avs_byteenable[1];
    assign wr_core = wr_ok & psm_hit(avs_address, PSM_CORE_OFS) & avs_byteenable[0];
    assign avs_readdata = rdata_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read | avs_write) & ~ack_q;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 32'h0;
        else if (rd_go)
        begin
            rdata_q <= 32'h0;
            if (psm_hit(avs_address, PSM_CTL_OFS))
            begin
                rdata_q[PSM_CTL_LDO_VOLTAGE_SELECT_LSB +: 2] <= ldo_voltage_select_q;
                rdata_q[PSM_CTL_STBSEL_BIT] <= stb_sel_q;
                rdata_q[PSM_CTL_REGULATOR_LOW_POWER_BIT] <= regulator_low_power_q;
            end
            else if (psm_hit(avs_address, PSM_STS_OFS))
            begin
                rdata_q[PSM_STS_WPEN_BIT] <= wpen_q;
                rdata_q[PSM_STS_STANDBY_ENTERED_FLAG_BIT] <= standby_entered_flag_q;
                rdata_q[PSM_STS_WUF_BIT] <= wuf_q;
            end
            else if (psm_hit(avs_address, PSM_CORE_OFS))
            begin
                rdata_q[PSM_CORE_DEEP_BIT] <= deep_q;
                rdata_q[PSM_CORE_SAI_BIT] <= sai_q;
                rdata_q[PSM_CORE_PAE_BIT] <= pae_q;
            end
        end
    end

    assign dom_rst = (state_q == PSM_POR);

    // Control bits lost with the core domain; reloaded by the POR sequence
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ldo_voltage_select_q <= PSM_LDO_VOLTAGE_SELECT_RST;
            stb_sel_q <= 1'b0;
            regulator_low_power_q <= 1'b0;
            deep_q <= 1'b0;
            sai_q <= 1'b0;
            pae_q <= 1'b0;
        end
        else if (dom_rst)
        begin
            ldo_voltage_select_q <= PSM_LDO_VOLTAGE_SELECT_RST;
            stb_sel_q <= 1'b0;
            regulator_low_power_q <= 1'b0;
            deep_q <= 1'b0;
            sai_q <= 1'b0;
            pae_q <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                stb_sel_q <= avs_writedata[PSM_CTL_STBSEL_BIT];
                regulator_low_power_q <= avs_writedata[PSM_CTL_REGULATOR_LOW_POWER_BIT];
            end
            if (wr_ctl && avs_byteenable[1] && !pll_on)
                ldo_voltage_select_q <= avs_writedata[PSM_CTL_LDO_VOLTAGE_SELECT_LSB +: 2];
            if (wr_core)
            begin
                deep_q <= avs_writedata[PSM_CORE_DEEP_BIT];
                sai_q <= avs_writedata[PSM_CORE_SAI_BIT];
                pae_q <= avs_writedata[PSM_CORE_PAE_BIT];
            end
        end
    end

    assign wake_rise = wake_pin & ~wake_prev_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wake_prev_q <= 1'b0;
        else
            wake_prev_q <= wake_pin;
    end

    // Status bits survive standby; set wins over clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wpen_q <= 1'b0;
            standby_entered_flag_q <= 1'b0;
            wuf_q <= 1'b0;
        end
        else
        begin
            if (wr_sts)
                wpen_q <= avs_writedata[PSM_STS_WPEN_BIT];
            if (state_q == PSM_STANDBY)
                standby_entered_flag_q <= 1'b1;
            else if (wr_ctl && avs_writedata[PSM_CTL_STBCLR_BIT])
                standby_entered_flag_q <= 1'b0;
            if (rtc_alarm || (wpen_q && wake_rise))
                wuf_q <= 1'b1;
            else if (wr_ctl && avs_writedata[PSM_CTL_WAKECLR_BIT])
                wuf_q <= 1'b0;
        end
    end

    assign wait_go = wfi_exec | wfe_exec;
    assign lwake = via_wfe_q ? (event_any | (pae_q & irq_any)) : irq_any;
    assign dwake = via_wfe_q ? (ext_line_event | (pae_q & ext_line_irq)) : ext_line_irq;
    assign swake = ~external_reset_pin_b | rtc_alarm | free_watchdog_rst
        | (wpen_q & wake_rise);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PSM_POR:
                if (cnt_q == 16'h0)
                    state_d = PSM_RUN;
            PSM_RUN:
                if (!deep_q && ((wait_go && !sai_q) || (sai_q && isr_exit_lowest)))
                    state_d = PSM_LSLEEP;
                else if (wait_go && deep_q && stb_sel_q)
                    state_d = PSM_STANDBY;
                else if (wait_go && deep_q && !ext_pending_any)
                    state_d = PSM_DSLEEP;
            PSM_LSLEEP:
                if (lwake)
                    state_d = PSM_RUN;
            PSM_DSLEEP:
                if (dwake)
                    state_d = PSM_DWAKE;
            PSM_DWAKE:
                if (cnt_q == 16'h0)
                    state_d = PSM_RUN;
            PSM_STANDBY:
                if (swake)
                    state_d = PSM_POR;
            default:
                state_d = PSM_POR;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= PSM_POR;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            via_wfe_q <= 1'b0;
        else if (state_q == PSM_RUN && wait_go)
            via_wfe_q <= wfe_exec;
        else if (state_q == PSM_RUN && isr_exit_lowest)
            via_wfe_q <= 1'b0;
    end

    // Countdown for reset sequence and deep-sleep exit delay
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 16'(POR_CYC - 1);
        else if (state_q == PSM_STANDBY)
            cnt_q <= 16'(POR_CYC - 1);
        else if (state_q == PSM_DSLEEP)
            cnt_q <= regulator_low_power_q ? 16'(OSC_CYC + LDO_CYC - 1) : 16'(OSC_CYC - 1);
        else if (cnt_q != 16'h0)
            cnt_q <= cnt_q - 16'h1;
    end

    // Registered outputs follow the next state
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_rst_b <= 1'b0;
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            osc_8m_en <= 1'b1;
            osc_48m_en <= 1'b1;
            high_speed_crystal_en <= 1'b1;
            pll_en <= 1'b1;
            ldo_en <= 1'b1;
            ldo_low_power <= 1'b0;
            domain_power_en <= 1'b1;
            io_float <= 1'b0;
        end
        else
        begin
            core_rst_b <= (state_d != PSM_POR);
            core_clk_en <= (state_d == PSM_RUN);
            periph_clk_en <= (state_d == PSM_RUN) || (state_d == PSM_LSLEEP);
            osc_8m_en <= (state_d != PSM_DSLEEP) && (state_d != PSM_STANDBY);
            osc_48m_en <= (state_d != PSM_DSLEEP) && (state_d != PSM_STANDBY);
            high_speed_crystal_en <= (state_d != PSM_DSLEEP) && (state_d != PSM_STANDBY);
            pll_en <= (state_d != PSM_DSLEEP) && (state_d != PSM_STANDBY);
            ldo_en <= (state_d != PSM_STANDBY);
            ldo_low_power <= (state_d == PSM_DSLEEP) && regulator_low_power_q;
            domain_power_en <= (state_d != PSM_STANDBY);
            io_float <= (state_d == PSM_STANDBY);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sysclk_to_8m <= 1'b0;
            ldo_voltage_out <= PSM_LDO_VOLTAGE_SELECT_LOW;
            wake_pin_keep <= 1'b0;
            boot_addr <= PSM_BOOT_ADDR;
        end
        else
        begin
            sysclk_to_8m <= (state_q == PSM_DWAKE) && (state_d == PSM_RUN);
            ldo_voltage_out <= pll_on ? ldo_voltage_select_q : PSM_LDO_VOLTAGE_SELECT_LOW;
            wake_pin_keep <= wpen_q;
            boot_addr <= PSM_BOOT_ADDR;
        end
    end
endmodule : psm_ctrl

// ==== psm_assertions.sv ====
`timescale 1ns/100ps
module psm_assertions
    import psm_pkg::*;
#(
    parameter int POR_CYC = 4 // Power-on count
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic [3:0] avs_address, // Address
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Data
    input wire logic [3:0] avs_byteenable, // Lanes
    input wire logic avs_waitrequest, // Stall
    input wire logic wfi_exec, // Wait instruction
    input wire logic ext_pending_any, // Pending flags
    input wire logic ext_line_irq, // Line interrupt
    input wire logic pll_on, // PLL running
    input wire logic core_rst_b, // Domain reset
    input wire logic core_clk_en, // Core clock
    input wire logic periph_clk_en, // Other clocks
    input wire logic pll_en, // PLL enable
    input wire logic ldo_low_power, // Regulator mode
    input wire logic [1:0] ldo_voltage_out, // Regulator level
    input wire logic domain_power_en, // Supply
    input wire logic io_float, // Pads float
    input wire logic sysclk_to_8m // Clock switch
);
    logic [2:0] core_q;
    logic [1:0] ctl_q;
    int por_n_q;
    logic acc;
    assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
    // Shadow of mode bits, cleared with the domain
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_q <= 3'h0;
            ctl_q <= 2'h0;
        end
        else if (!core_rst_b)
        begin
            core_q <= 3'h0;
            ctl_q <= 2'h0;
        end
        else if (acc && avs_address[3:2] == 2'h2)
            core_q <= avs_writedata[2:0];
        else if (acc && avs_address[3:2] == 2'h0)
            ctl_q <= avs_writedata[1:0];
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            por_n_q <= 0;
        else if (core_rst_b || !domain_power_en)
            por_n_q <= 0;
        else
            por_n_q <= por_n_q + 1;
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_light;
        core_clk_en && wfi_exec && core_q == 3'h0;
    endsequence
    sequence s_deep;
        core_clk_en && wfi_exec && core_q[1:0] == 2'h1 && !ctl_q[1] && !ext_pending_any;
    endsequence
    sequence s_pend;
        core_clk_en && wfi_exec && core_q[1:0] == 2'h1 && !ctl_q[1] && ext_pending_any;
    endsequence
    sequence s_stby;
        core_clk_en && wfi_exec && core_q[1:0] == 2'h1 && ctl_q[1];
    endsequence
    por_len_a: assert property ($rose(core_rst_b) |->
        por_n_q >= POR_CYC - 1 && por_n_q <= POR_CYC + 2) else $error("power-on length");
    run_full_a: assert property ($rose(core_rst_b) |-> core_clk_en && periph_clk_en)
        else $error("not fully running");
    light_in_a: assert property (s_light |=> !core_clk_en && periph_clk_en)
        else $error("light sleep entry");
    deep_in_a: assert property (s_deep |=> !periph_clk_en && !pll_en
        && ldo_low_power == ctl_q[0]) else $error("deep sleep entry");
    deep_skip_a: assert property (s_pend |=> core_clk_en [*2])
        else $error("deep entry not skipped");
    deep_out_a: assert property ($rose(ext_line_irq) && !periph_clk_en && core_rst_b
        && domain_power_en |-> ##[1:16] sysclk_to_8m) else $error("deep wake missing");
    sysclk_one_a: assert property (sysclk_to_8m |=> !sysclk_to_8m)
        else $error("clock switch not a pulse");
    stby_in_a: assert property (s_stby |=> !domain_power_en && io_float && !pll_en)
        else $error("standby entry");
    ldo_low_a: assert property (!pll_on && !$past(pll_on) |->
        ldo_voltage_out == PSM_LDO_VOLTAGE_SELECT_LOW) else $error("low level with PLL off");
endmodule : psm_assertions

// ==== psm_core_model.sv ====
`timescale 1ns/100ps
module psm_core_model (
    input wire logic clk, // Clock
    output logic [12:0] src // Core and wake lines
);
    // 0 wfi, 1 wfe, 2 isr exit, 3 irq, 4 event, 5 line irq, 6 line event,
    // 7 pending, 8 pll, 9 reset pin low, 10 rtc, 11 watchdog, 12 wake pin
    initial src = 13'h0;
    task automatic hold(input int n, input logic v);
        src[n] <= v;
        @(posedge clk);
    endtask : hold
    // Modes are set over the bus before any wait pulse
    task automatic pulse(input int n);
        hold(n, 1'b1);
        hold(n, 1'b0);
        @(posedge clk);
    endtask : pulse
endmodule : psm_core_model

// ==== psm_ctrl_bench.sv ====
`timescale 1ns/100ps
module psm_ctrl_bench;
    import psm_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, boot_addr, exp_q[$];
    logic avs_waitrequest, core_rst_b, core_clk_en, periph_clk_en, osc_8m_en, osc_48m_en;
    logic high_speed_crystal_en, pll_en, ldo_en, ldo_low_power, domain_power_en, sysclk_to_8m, io_float;
    logic wake_pin_keep;
    logic [1:0] ldo_voltage_out;
    logic [12:0] src;
    int n_errors = 0;
    int checks_done = 0;
    int lat[2];
    int lt[3][4] = '{'{0, 0, 4, 3}, '{1, 0, 3, 4}, '{1, 1, 7, 3}};
    int ws[4] = '{12, 10, 11, 9};
    always #20 clk = ~clk;
    psm_core_model m (.clk(clk), .src(src));
    psm_ctrl #(.POR_CYC(4), .OSC_CYC(3), .LDO_CYC(5)) DUT (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wfi_exec(src[0]),
        .wfe_exec(src[1]), .isr_exit_lowest(src[2]), .irq_any(src[3]), .event_any(src[4]),
        .ext_line_irq(src[5]), .ext_line_event(src[6]), .ext_pending_any(src[7]),
        .pll_on(src[8]), .external_reset_pin_b(!src[9]), .rtc_alarm(src[10]),
        .free_watchdog_rst(src[11]), .wake_pin(src[12]), .core_rst_b(core_rst_b),
        .boot_addr(boot_addr), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
        .osc_8m_en(osc_8m_en), .osc_48m_en(osc_48m_en), .high_speed_crystal_en(high_speed_crystal_en), .pll_en(pll_en),
        .ldo_en(ldo_en), .ldo_low_power(ldo_low_power), .ldo_voltage_out(ldo_voltage_out),
        .domain_power_en(domain_power_en), .sysclk_to_8m(sysclk_to_8m), .io_float(io_float),
        .wake_pin_keep(wake_pin_keep));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // Request held until waitrequest is seen low, one idle edge after
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        chk("bus answer", 32'h2, 32'(n));
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    task automatic wait_run();
        int n;
        n = 0;
        while (core_rst_b !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk("domain out of reset", 32'h1, {31'h0, core_rst_b});
    endtask : wait_run
    always @(posedge clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            chk("readdata", exp_q.pop_front(), avs_readdata);
    end
    initial
    begin
        #2000000;
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(90));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        wait_run();
        chk("clocks", 32'hff, {24'h0, core_clk_en, periph_clk_en, osc_8m_en, osc_48m_en,
            high_speed_crystal_en, pll_en, ldo_en, domain_power_en});
        rd(PSM_CTL_OFS, 32'h4000);
        rd(PSM_STS_OFS, 32'h0);
        bus(1'b1, 4'hc, $urandom, 4'hf);
        rd(4'hc, 32'h0);
        m.hold(8, 1'b1);
        bus(1'b1, PSM_CTL_OFS, 32'h8000, 4'h3);
        rd(PSM_CTL_OFS, 32'h4000);
        chk("level with PLL", 32'h1, {30'h0, ldo_voltage_out});
        m.hold(8, 1'b0);
        bus(1'b1, PSM_CTL_OFS, 32'h8000, 4'h3);
        rd(PSM_CTL_OFS, 32'h8000);
        chk("level without PLL", 32'h0, {30'h0, ldo_voltage_out});
        foreach (lt[i])
        begin
            bus(1'b1, PSM_CORE_OFS, 32'(lt[i][1] << 2), 4'h1);
            m.pulse(lt[i][0]);
            chk("light clocks", 32'h1, {30'h0, core_clk_en, periph_clk_en});
            m.pulse(lt[i][2]);
            chk("still asleep", 32'h0, {31'h0, core_clk_en});
            m.pulse(lt[i][3]);
            chk("woken", 32'h1, {31'h0, core_clk_en});
        end
        bus(1'b1, PSM_CORE_OFS, 32'h2, 4'h1);
        m.pulse(0);
        chk("awake at wait", 32'h1, {31'h0, core_clk_en});
        m.pulse(2);
        chk("asleep after handler", 32'h0, {31'h0, core_clk_en});
        m.pulse(3);
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, PSM_CTL_OFS, 32'(32'h8001 - i), 4'h3);
            bus(1'b1, PSM_CORE_OFS, 32'h1, 4'h1);
            // First pass enters by wait_for_interrupt, second by wait_for_event
            m.hold(7, 1'b1);
            m.pulse(i);
            chk("deep skipped", 32'h1, {31'h0, core_clk_en});
            m.hold(7, 1'b0);
            m.pulse(i);
            chk("deep clocks", 32'h0, {27'h0, periph_clk_en, osc_8m_en, osc_48m_en,
                high_speed_crystal_en, pll_en});
            chk("regulator mode", 32'(1 - i), {31'h0, ldo_low_power});
            m.pulse(3);
            chk("deep kept", 32'h0, {31'h0, periph_clk_en});
            m.hold(5 + i, 1'b1);
            lat[i] = 0;
            while (sysclk_to_8m !== 1'b1 && lat[i] < 40)
            begin
                @(posedge clk);
                lat[i]++;
            end
            chk("clock switch", 32'h1, {31'h0, sysclk_to_8m});
            m.hold(5 + i, 1'b0);
        end
        chk("regulator delay", 32'h5, 32'(lat[0] - lat[1]));
        foreach (ws[k])
        begin
            bus(1'b1, PSM_STS_OFS, 32'h100, 4'h2);
            bus(1'b1, PSM_CTL_OFS, 32'h800e, 4'h3);
            bus(1'b1, PSM_CORE_OFS, 32'h1, 4'h1);
            m.pulse(0);
            chk("standby", 32'h3, {28'h0, ldo_en, domain_power_en, io_float, wake_pin_keep});
            m.pulse(ws[k]);
            wait_run();
            chk("boot address", 32'h0, boot_addr);
            rd(PSM_STS_OFS, 32'h102 | 32'(k < 2));
            rd(PSM_CTL_OFS, 32'h4000);
            rd(PSM_CORE_OFS, 32'h0);
        end
        bus(1'b1, PSM_CTL_OFS, 32'h400c, 4'h3);
        rd(PSM_STS_OFS, 32'h100);
        report_and_stop();
    end
endmodule : psm_ctrl_bench
bind psm_ctrl psm_assertions #(.POR_CYC(POR_CYC)) u_chk (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .wfi_exec(wfi_exec),
    .ext_pending_any(ext_pending_any), .ext_line_irq(ext_line_irq), .pll_on(pll_on),
    .core_rst_b(core_rst_b), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .pll_en(pll_en), .ldo_low_power(ldo_low_power), .ldo_voltage_out(ldo_voltage_out),
    .domain_power_en(domain_power_en), .io_float(io_float), .sysclk_to_8m(sysclk_to_8m));
